//--- shared/lwsram_pkg.sv
`default_nettype none
package lwsram_pkg;
  // =====================================================
  // organisation
  localparam int LWS_LANE_W = 9;
  localparam int LWS_WIDE_LANES = 4;
  localparam int LWS_WIDE_ADDR_W = 18;
  localparam int LWS_NARROW_LANES = 2;
  localparam int LWS_NARROW_ADDR_W = 19;
  // =====================================================
  // command decode at the rising edge
  typedef enum logic [1:0] {
    LWS_CMD_DESEL,
    LWS_CMD_READ,
    LWS_CMD_WRITE
  } lws_cmd_t;
endpackage : lwsram_pkg
`default_nettype wire

//--- shared/lwsram_wbuf_if.sv
`timescale 1ns/1ps
`default_nettype none
interface lwsram_wbuf_if #(
  parameter int AW = 18,
  parameter int LANES = 4,
  parameter int LANE_W = 9
);
  logic load;
  logic [AW-1:0] load_addr;
  logic [LANES-1:0] load_be;
  logic [LANES*LANE_W-1:0] load_data;
  logic valid;
  logic [AW-1:0] addr;
  logic [LANES-1:0] be;
  logic [LANES*LANE_W-1:0] data;
  modport owner (output load, output load_addr, output load_be,
    output load_data, input valid, input addr, input be, input data);
  modport buffer (input load, input load_addr, input load_be,
    input load_data, output valid, output addr, output be, output data);
endinterface : lwsram_wbuf_if
`default_nettype wire

//--- src/lwsram_wbuf.sv
`timescale 1ns/1ps
`default_nettype none
module lwsram_wbuf
  import lwsram_pkg::*;
#(
  parameter int AW = 18,
  parameter int LANES = 4,
  parameter int LANE_W = 9
) (
  input wire logic clk,
  input wire logic rst,
  lwsram_wbuf_if.buffer wb
);
  // =====================================================
  // single entry late write buffer
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wb.valid <= 1'b0;
      wb.addr <= '0;
      wb.be <= '0;
      wb.data <= '0;
    end else if (wb.load) begin
      wb.valid <= 1'b1;
      wb.addr <= wb.load_addr;
      wb.be <= wb.load_be;
      wb.data <= wb.load_data;
    end
  end
endmodule : lwsram_wbuf
`default_nettype wire

//--- src/lwsram_port.sv
`timescale 1ns/1ps
`default_nettype none
module lwsram_port
  import lwsram_pkg::*;
#(
  parameter bit WIDE = 1'b1,
  parameter int LANES = WIDE ? LWS_WIDE_LANES : LWS_NARROW_LANES,
  parameter int AW = WIDE ? LWS_WIDE_ADDR_W : LWS_NARROW_ADDR_W,
  parameter int DW = LANES * LWS_LANE_W
) (
  input wire logic CLOCK,
  input wire logic RST,
  input wire logic [AW-1:0] ADDRESS_IN,
  input wire logic SELECT_N,
  input wire logic WRITE_ENABLE_N,
  input wire logic [LANES-1:0] BYTE_WRITE_N,
  input wire logic OUTPUT_ENABLE_N,
  input wire logic SLEEP_REQUEST,
  input wire logic READ_PROTOCOL_HIGH_PIN,
  input wire logic READ_PROTOCOL_LOW_PIN,
  input wire logic [DW-1:0] DQ_IN,
  output logic [DW-1:0] DQ_OUT,
  output logic DQ_OE_N
);
  localparam int DEPTH = 1 << AW;

  // =====================================================
  // input capture
  // inputs are on CLOCK itself (synchronous pins), so no synchroniser;
  // the two mode pins are straps and read by nothing here.
  logic [AW-1:0] addr_reg;
  logic [LANES-1:0] be_reg;
  lws_cmd_t cmd_reg;
  lws_cmd_t cmd_next;
  logic [DW-1:0] arr_word;
  lwsram_wbuf_if #(.AW(AW), .LANES(LANES), .LANE_W(LWS_LANE_W)) wb ();

  function automatic lws_cmd_t decode(input logic sel_n, input logic we_n);
    if (sel_n) decode = LWS_CMD_DESEL;
    else if (we_n) decode = LWS_CMD_READ;
    else decode = LWS_CMD_WRITE;
  endfunction : decode

  // sleep gates commands combinationally: no clock needed to enter
  assign cmd_next = SLEEP_REQUEST ? LWS_CMD_DESEL
      : decode(SELECT_N, WRITE_ENABLE_N);

  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      cmd_reg <= LWS_CMD_DESEL;
      addr_reg <= '0;
      be_reg <= '1;
    end else begin
      cmd_reg <= cmd_next;
      addr_reg <= ADDRESS_IN;
      be_reg <= BYTE_WRITE_N;
    end
  end

  // =====================================================
  // late write: data arrives one edge after the command
  logic wr_phase;
  logic [LANES-1:0] wr_be;
  assign wr_phase = (cmd_reg == LWS_CMD_WRITE) && !SLEEP_REQUEST;
  assign wr_be = ~be_reg;
  assign wb.load = wr_phase && (wr_be != '0);
  assign wb.load_addr = addr_reg;
  assign wb.load_be = wr_be;
  assign wb.load_data = DQ_IN;

  lwsram_wbuf #(.AW(AW), .LANES(LANES), .LANE_W(LWS_LANE_W)) u_wbuf (
    .clk(CLOCK),
    .rst(RST),
    .wb(wb)
  );

  // retire the buffer into the array when a newer write replaces it
  // one array per lane, so every lane store has a single writer
  genvar g;
  generate
    for (g = 0; g < LANES; g++) begin : g_lane
      logic [LWS_LANE_W-1:0] lane_mem [DEPTH];
      always_ff @(posedge CLOCK) begin
        if (wb.load && wb.valid && wb.be[g]) begin
          lane_mem[wb.addr] <= wb.data[g*LWS_LANE_W +: LWS_LANE_W];
        end
      end
      assign arr_word[g*LWS_LANE_W +: LWS_LANE_W] = lane_mem[addr_reg];
    end
  endgenerate

  // =====================================================
  // read path with buffer coherency
  logic [DW-1:0] merged;
  logic hit;
  assign hit = wb.valid && (wb.addr == addr_reg);
  generate
    for (g = 0; g < LANES; g++) begin : g_merge
      assign merged[g*LWS_LANE_W +: LWS_LANE_W] = (hit && wb.be[g])
        ? wb.data[g*LWS_LANE_W +: LWS_LANE_W]
        : arr_word[g*LWS_LANE_W +: LWS_LANE_W];
    end
  endgenerate

  // falling-edge output latch, half a cycle after the read edge
  logic [DW-1:0] q_reg;
  logic rd_drive_reg;
  always_ff @(negedge CLOCK or posedge RST) begin
    if (RST) begin
      q_reg <= '0;
      rd_drive_reg <= 1'b0;
    end else begin
      rd_drive_reg <= (cmd_reg == LWS_CMD_READ);
      if (cmd_reg == LWS_CMD_READ) q_reg <= merged;
    end
  end

  // drive stays up until the next falling edge; oe and sleep act at once
  assign DQ_OUT = q_reg;
  assign DQ_OE_N =
    !(rd_drive_reg && !OUTPUT_ENABLE_N && !SLEEP_REQUEST);

  // =====================================================
  // checks
  property p_oe_float;
    @(posedge CLOCK) disable iff (RST)
      (OUTPUT_ENABLE_N || SLEEP_REQUEST) |-> DQ_OE_N;
  endproperty
  a_oe_float: assert property (p_oe_float)
    else $error("data driven while disabled");

  property p_sleep_no_cmd;
    @(posedge CLOCK) disable iff (RST)
      SLEEP_REQUEST |=> (cmd_reg == LWS_CMD_DESEL);
  endproperty
  a_sleep_no_cmd: assert property (p_sleep_no_cmd)
    else $error("command taken during sleep");

  property p_read_cmd;
    @(posedge CLOCK) disable iff (RST)
      (!SLEEP_REQUEST && !SELECT_N && WRITE_ENABLE_N)
        |=> (cmd_reg == LWS_CMD_READ);
  endproperty
  a_read_cmd: assert property (p_read_cmd)
    else $error("read not decoded");

  property p_desel;
    @(posedge CLOCK) disable iff (RST)
      SELECT_N |=> (cmd_reg == LWS_CMD_DESEL);
  endproperty
  a_desel: assert property (p_desel)
    else $error("deselect not decoded");

  property p_late_write;
    @(posedge CLOCK) disable iff (RST)
      (!SLEEP_REQUEST && !SELECT_N && !WRITE_ENABLE_N && !(&BYTE_WRITE_N))
        ##1 !SLEEP_REQUEST |=> (wb.valid && wb.data == $past(DQ_IN));
  endproperty
  a_late_write: assert property (p_late_write)
    else $error("late write data not buffered");

  property p_abort;
    @(posedge CLOCK) disable iff (RST)
      (cmd_reg == LWS_CMD_WRITE && (&be_reg)) |-> !wb.load;
  endproperty
  a_abort: assert property (p_abort)
    else $error("aborted write loaded");

  property p_lanes;
    @(posedge CLOCK) disable iff (RST)
      wb.load |=> (wb.be == ~$past(be_reg));
  endproperty
  a_lanes: assert property (p_lanes)
    else $error("byte lanes wrong");

  property p_read_out;
    @(posedge CLOCK) disable iff (RST)
      (cmd_reg == LWS_CMD_READ) |-> (rd_drive_reg && DQ_OUT == merged);
  endproperty
  a_read_out: assert property (p_read_out)
    else $error("read data not presented");

  property p_idle_float;
    @(posedge CLOCK) disable iff (RST)
      (cmd_reg != LWS_CMD_READ) |-> DQ_OE_N;
  endproperty
  a_idle_float: assert property (p_idle_float)
    else $error("data driven without a read");

  property p_no_stray_load;
    @(posedge CLOCK) disable iff (RST)
      (cmd_reg != LWS_CMD_WRITE) |-> !wb.load;
  endproperty
  a_no_stray_load: assert property (p_no_stray_load)
    else $error("buffer loaded without a write");

  property p_load_addr;
    @(posedge CLOCK) disable iff (RST)
      wb.load |=> (wb.valid && wb.addr == $past(addr_reg));
  endproperty
  a_load_addr: assert property (p_load_addr)
    else $error("write address not buffered");

  property p_wbuf_hold;
    @(posedge CLOCK) disable iff (RST)
      !wb.load |=> ($stable(wb.addr) && $stable(wb.data) && $stable(wb.be));
  endproperty
  a_wbuf_hold: assert property (p_wbuf_hold)
    else $error("buffer changed without a load");
endmodule : lwsram_port
`default_nettype wire

//--- testbench/lwsram_ctrl_model.sv
`timescale 1ns/1ps
`default_nettype none
// =====
// far-side controller: straps and bus
module lwsram_ctrl_model #(parameter int DW = 36) (
  input wire logic clk,
  input wire logic host_drive,
  input wire logic [DW-1:0] host_data,
  input wire logic [DW-1:0] dq_out,
  input wire logic dq_oe_n,
  output logic [DW-1:0] dq_in,
  output logic mode_hi,
  output logic mode_lo
);
  logic [DW-1:0] last_reg = '0;
  assign mode_hi = 1'b1;
  assign mode_lo = 1'b0;
  // idle bus toggles so no stale value looks valid
  assign dq_in = host_drive ? host_data : (!dq_oe_n ? dq_out : ~last_reg);
  always_ff @(posedge clk) begin
    last_reg <= dq_in;
  end
endmodule : lwsram_ctrl_model
`default_nettype wire

//--- testbench/late_write_sync_sram_port_test.sv
`timescale 1ns/1ps
`default_nettype none
module late_write_sync_sram_port_test;
  import lwsram_pkg::*;
  localparam int DW = 36;
  logic clk = 0, rst = 1, sel_n = 1, we_n = 1, oe_n = 0, slp = 0;
  logic hdrv = 0, pw = 0, rd_prev = 0, m_hi, m_lo, dq_oe_n;
  logic [17:0] addr = '0;
  logic [3:0] bw_n = 4'hf;
  logic [DW-1:0] hdata = '0, pd = '0, exp_prev, dq_in, dq_out;
  logic [DW-1:0] mem [int];
  logic [31:0] seed = 32'd51;
  int failures = 0, compares = 0;
  always #20 clk = ~clk;
  lwsram_port u_lwsram_port (.CLOCK(clk), .RST(rst), .ADDRESS_IN(addr),
    .SELECT_N(sel_n), .WRITE_ENABLE_N(we_n), .BYTE_WRITE_N(bw_n),
    .OUTPUT_ENABLE_N(oe_n), .SLEEP_REQUEST(slp),
    .READ_PROTOCOL_HIGH_PIN(m_hi), .READ_PROTOCOL_LOW_PIN(m_lo),
    .DQ_IN(dq_in), .DQ_OUT(dq_out), .DQ_OE_N(dq_oe_n));
  lwsram_ctrl_model u_lwsram_ctrl_model (.clk(clk), .host_drive(hdrv),
    .host_data(hdata), .dq_out(dq_out), .dq_oe_n(dq_oe_n),
    .dq_in(dq_in), .mode_hi(m_hi), .mode_lo(m_lo));
  // =====
  // expectation helpers
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd
  function automatic logic [DW-1:0] merge(logic [DW-1:0] o, logic [DW-1:0] d,
    logic [3:0] bn);
    logic [DW-1:0] m;
    for (int g = 0; g < 4; g++) m[9*g +: 9] = {9{~bn[g]}};
    return (o & ~m) | (d & m);
  endfunction : merge
  task automatic chk_dq(logic [DW-1:0] e);
    compares++;
    if (dq_out !== e) begin
      failures++;
      $display("unexpected at %0t: data %h want %h", $time, dq_out, e);
    end
  endtask : chk_dq
  task automatic chk_oe(logic e);
    compares++;
    if (dq_oe_n !== e) begin
      failures++;
      $display("unexpected at %0t: drive enable %b", $time, dq_oe_n);
    end
  endtask : chk_oe
  // k: 0 deselect, 1 read, 2 write; checks the previous command
  task automatic op(int k, logic [17:0] a, logic [3:0] bn, logic [DW-1:0] d,
    logic o = 1'b0, logic s = 1'b0);
    @(posedge clk);
    #1;
    oe_n = o;
    slp = s;
    sel_n = (k == 0);
    we_n = (k != 2);
    addr = a;
    bw_n = bn;
    hdrv = pw;
    hdata = pd;
    pw = (k == 2) && !slp;
    pd = d;
    if (pw) mem[a] = merge(mem[a], d, bn);
    @(negedge clk);
    #1;
    chk_oe(!(rd_prev && !oe_n && !slp));
    if (rd_prev && !oe_n && !slp) chk_dq(exp_prev);
    rd_prev = (k == 1) && !slp;
    if (rd_prev) exp_prev = mem[a];
  endtask : op
  task automatic tally_and_finish();
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : tally_and_finish
  initial begin
    #100000;
    failures++;
    tally_and_finish();
  end
  initial begin
    logic [31:0] r;
    repeat (2) @(posedge clk);
    #1;
    rst = 0;
    for (int i = 0; i < 8; i++) op(2, 18'(i), 4'h0, {rnd(), 4'h5});
    op(2, 18'h3ffff, 4'h0, {4'ha, rnd()});
    op(1, 18'h3ffff, 4'hf, '0);
    $display("test fill done");
    for (int i = 0; i < 300; i++) begin
      r = rnd();
      op(r[1:0] % 3, 18'(r[4:2]), r[8:5], {rnd(), r[31:28]},
        r[9] & r[10]);
    end
    $display("test random done");
    op(1, '0, 4'hf, '0);
    op(2, '0, 4'h0, '1, 1'b0, 1'b1);
    op(1, '0, 4'hf, '0, 1'b0, 1'b1);
    op(0, '0, 4'hf, '0, 1'b0, 1'b1);
    op(1, '0, 4'hf, '0);
    op(0, '0, 4'hf, '0);
    $display("test sleep done");
    tally_and_finish();
  end
endmodule : late_write_sync_sram_port_test
`default_nettype wire
